// >>> hdl/flag_word_reg.sv
// one software-writable word whose bits may also be set by hardware events
`timescale 1ns/1ps
module flag_word_reg
  import irq_flag_pkg::*;
#(
  parameter int          WIDTH     = 16,
  parameter logic [15:0] IMPL_MASK = 16'hFFFF
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // hardware set and software write
  input  wire logic [WIDTH-1:0] set_bits,
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wr_data,
  // stored value
  output logic      [WIDTH-1:0] value
);

  logic [WIDTH-1:0] value_reg;
  logic [WIDTH-1:0] value_next;
  logic [WIDTH-1:0] impl;

  if (WIDTH < 1 || WIDTH > 16) begin : g_bad_width
    $error("flag_word_reg: WIDTH must be 1 to 16");
  end

  assign impl = IMPL_MASK[WIDTH-1:0];

  // event set wins over a software write of zero
  always_comb begin
    value_next = (wr_en ? wr_data : value_reg) | set_bits;
    value_next = value_next & impl;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      value_reg <= {WIDTH{1'b0}};
    end else begin
      value_reg <= value_next;
    end
  end

  assign value = value_reg;

endmodule

// >>> hdl/interrupt_flag_enable_bank.sv
// interrupt flag and enable register bank behind an ahb-lite slave
//
// Contract
// - a flag bit reads 1 once its source raised a request and 0 if none came since it was cleared.
// - an enable bit at 1 lets its source's request through and at 0 blocks it; only request_out is gated, irq_status_reg takes the events ungated.
//   here only enable_control_2 bits 2..0 gate a request; enable_control_0, enable_control_1 and the other enable_control_2 bits gate nothing.
// - unimplemented bits of every flag and enable register read zero and ignore writes.
// - every implemented flag and enable bit can be read and written by software.
// - all flag and enable bits are zero after power-on reset.
// - flag_status_2 bit 2 is can1 receive, bit 1 serial2 event, bit 0 serial2 error.
// - flag_status_3 bits 13,12,11,8,7 are dma5 done, codec event, codec error, can2 event, can2 receive.
// - flag_status_3 bits 6..0 are ext irq 4 and 3, timers 9 and 8, i2c2 master and slave, timer 7.
// - flag_status_4 bits 7..4 are can2/can1 transmit and dma7/dma6 done, bits 2,1 uart2/uart1 errors.
// - enable_control_0 bit 15 is unused and bits 14..8 enable dma1, adc1, uart1 tx/rx, serial1 event/error, timer3.
// - enable_control_0 bits 7..0 enable timer2, compare2, capture2, dma0, timer1, compare1, capture1, ext irq 0.
// - enable_control_1 bits 15..8 enable uart2 tx/rx, ext irq 2, timers 5 and 4, compares 4 and 3, dma2.
// - enable_control_1 bits 7..3 enable capture 8/7, adc2, ext irq 1, pin change; bit 2 unused; bits 1,0 i2c1.
// - enable_control_2 bits 15,14 enable timer6 and dma4, bit 13 unused, bits 12..9 compares 8..5, bit 8 capture6.
`timescale 1ns/1ps
module interrupt_flag_enable_bank
  import irq_flag_pkg::*;
(
  // clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // ahb-lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic      [31:0]       hrdata,
  // peripheral event pulses, one bit per flag position
  input  wire logic [REG_W-1:0]  flag2_events,
  input  wire logic [REG_W-1:0]  flag3_events,
  input  wire logic [REG_W-1:0]  flag4_events,
  // register contents towards the vector logic
  output logic      [REG_W-1:0]  flag_status_3,
  output logic      [REG_W-1:0]  flag_status_4,
  output logic      [REG_W-1:0]  enable_control_0,
  output logic      [REG_W-1:0]  enable_control_1,
  // forwarded requests of the paired flag_status_2 sources
  output logic      [EVT_W-1:0]  request_out,
  // summary interrupt
  output logic                   irq
);

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  logic              access_take;
  logic              wr_phase_reg;
  logic [7:0]        addr_reg;
  logic              rd_take;
  logic [7:0]        rd_addr;
  logic [31:0]       hrdata_reg;
  logic [31:0]       hrdata_next;
  logic [REG_W-1:0]  flag_status_2;
  logic [REG_W-1:0]  enable_control_2;
  logic [EVT_W-1:0]  irq_status_reg;
  logic [EVT_W-1:0]  irq_status_next;
  logic [EVT_W-1:0]  irq_mask_reg;
  logic [EVT_W-1:0]  irq_events;
  logic              wr_flag2;
  logic              wr_flag3;
  logic              wr_flag4;
  logic              wr_en0;
  logic              wr_en1;
  logic              wr_en2;
  logic [REG_W-1:0]  wdata;

  assign access_take = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign rd_take     = access_take && !hwrite;
  assign rd_addr     = {haddr[ADDR_MSB:ADDR_LSB], 2'b00};
  assign hreadyout   = 1'b1;
  assign hresp       = HRESP_OKAY;
  assign wdata       = hwdata[REG_W-1:0];

  // write address is held for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_phase_reg <= 1'b0;
      addr_reg     <= 8'h00;
    end else begin
      wr_phase_reg <= access_take && hwrite;
      if (access_take) begin
        addr_reg <= rd_addr;
      end
    end
  end

  assign wr_flag2 = wr_phase_reg && (addr_reg == OFF_FLAG2);
  assign wr_flag3 = wr_phase_reg && (addr_reg == OFF_FLAG3);
  assign wr_flag4 = wr_phase_reg && (addr_reg == OFF_FLAG4);
  assign wr_en0   = wr_phase_reg && (addr_reg == OFF_EN0);
  assign wr_en1   = wr_phase_reg && (addr_reg == OFF_EN1);
  assign wr_en2   = wr_phase_reg && (addr_reg == OFF_EN2);

  ////////////////////////////////////////////////////////////////////////////
  // flag and enable words

  flag_word_reg #(.WIDTH(REG_W), .IMPL_MASK(MASK_FLAG2)) u_flag2 (
    .clk      (hclk),
    .rst_n    (hresetn),
    .set_bits (flag2_events),
    .wr_en    (wr_flag2),
    .wr_data  (wdata),
    .value    (flag_status_2)
  );

  flag_word_reg #(.WIDTH(REG_W), .IMPL_MASK(MASK_FLAG3)) u_flag3 (
    .clk      (hclk),
    .rst_n    (hresetn),
    .set_bits (flag3_events),
    .wr_en    (wr_flag3),
    .wr_data  (wdata),
    .value    (flag_status_3)
  );

  flag_word_reg #(.WIDTH(REG_W), .IMPL_MASK(MASK_FLAG4)) u_flag4 (
    .clk      (hclk),
    .rst_n    (hresetn),
    .set_bits (flag4_events),
    .wr_en    (wr_flag4),
    .wr_data  (wdata),
    .value    (flag_status_4)
  );

  // enable words have no hardware set source
  flag_word_reg #(.WIDTH(REG_W), .IMPL_MASK(MASK_EN0)) u_en0 (
    .clk      (hclk),
    .rst_n    (hresetn),
    .set_bits ({REG_W{1'b0}}),
    .wr_en    (wr_en0),
    .wr_data  (wdata),
    .value    (enable_control_0)
  );

  flag_word_reg #(.WIDTH(REG_W), .IMPL_MASK(MASK_EN1)) u_en1 (
    .clk      (hclk),
    .rst_n    (hresetn),
    .set_bits ({REG_W{1'b0}}),
    .wr_en    (wr_en1),
    .wr_data  (wdata),
    .value    (enable_control_1)
  );

  flag_word_reg #(.WIDTH(REG_W), .IMPL_MASK(MASK_EN2)) u_en2 (
    .clk      (hclk),
    .rst_n    (hresetn),
    .set_bits ({REG_W{1'b0}}),
    .wr_en    (wr_en2),
    .wr_data  (wdata),
    .value    (enable_control_2)
  );

  // only the flag_status_2 sources have both their flags and their enables in this bank
  assign request_out = flag_status_2[EVT_W-1:0] & enable_control_2[EVT_W-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status, mask and summary output

  assign irq_events[B_IRQ_FLAG2] = |(flag2_events & MASK_FLAG2);
  assign irq_events[B_IRQ_FLAG3] = |(flag3_events & MASK_FLAG3);
  assign irq_events[B_IRQ_FLAG4] = |(flag4_events & MASK_FLAG4);

  // a read clears, an event in the same cycle still sets
  always_comb begin
    irq_status_next = irq_status_reg;
    if (rd_take && (rd_addr == OFF_IRQ_STAT)) begin
      irq_status_next = {EVT_W{1'b0}};
    end
    irq_status_next = irq_status_next | irq_events;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status_reg <= {EVT_W{1'b0}};
    end else begin
      irq_status_reg <= irq_status_next;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask_reg <= {EVT_W{1'b0}};
    end else if (wr_phase_reg && (addr_reg == OFF_IRQ_MASK)) begin
      irq_mask_reg <= hwdata[EVT_W-1:0] & MASK_IRQ;
    end
  end

  assign irq = |(irq_status_reg & irq_mask_reg);

  ////////////////////////////////////////////////////////////////////////////
  // read data, captured in the address phase

  always_comb begin
    hrdata_next = 32'h0000_0000;
    case (rd_addr)
      OFF_FLAG2:    hrdata_next = {16'h0000, flag_status_2};
      OFF_FLAG3:    hrdata_next = {16'h0000, flag_status_3};
      OFF_FLAG4:    hrdata_next = {16'h0000, flag_status_4};
      OFF_EN0:      hrdata_next = {16'h0000, enable_control_0};
      OFF_EN1:      hrdata_next = {16'h0000, enable_control_1};
      OFF_EN2:      hrdata_next = {16'h0000, enable_control_2};
      OFF_IRQ_STAT: hrdata_next = {29'h0000_0000, irq_status_reg};
      OFF_IRQ_MASK: hrdata_next = {29'h0000_0000, irq_mask_reg};
      default:      hrdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (rd_take) begin
      hrdata_reg <= hrdata_next;
    end
  end

  assign hrdata = hrdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_read_take(logic [7:0] off);
    rd_take && (rd_addr == off);
  endsequence

  sequence s_write_phase(logic [7:0] off);
    wr_phase_reg && (addr_reg == off);
  endsequence

  sequence s_status_read_quiet;
    rd_take && (rd_addr == OFF_IRQ_STAT) && !(|irq_events);
  endsequence

  a_flag_event_sets: assert property (
    flag3_events[B_TIMER7] |=> flag_status_3[B_TIMER7] ##1
      (flag_status_3[B_TIMER7] || $past(wr_flag3)))
    else $error("flag not held after its event");

  a_event_beats_clear: assert property (
    (flag4_events[B_UART1_ERROR] && wr_flag4 && !hwdata[B_UART1_ERROR]) |=> flag_status_4[B_UART1_ERROR])
    else $error("event lost against software clear");

  a_flag_write_clears: assert property (
    (wr_flag3 && !hwdata[B_CAN2_EVENT] && !flag3_events[B_CAN2_EVENT]) |=> !flag_status_3[B_CAN2_EVENT])
    else $error("flag not cleared by write of zero");

  a_unimpl_zero: assert property (
    ((flag_status_2 & ~MASK_FLAG2) == 16'h0000) && ((flag_status_3 & ~MASK_FLAG3) == 16'h0000) &&
    ((flag_status_4 & ~MASK_FLAG4) == 16'h0000) && ((enable_control_0 & ~MASK_EN0) == 16'h0000) &&
    ((enable_control_1 & ~MASK_EN1) == 16'h0000) && ((enable_control_2 & ~MASK_EN2) == 16'h0000))
    else $error("unimplemented bit is set");

  a_enable_write: assert property (
    s_write_phase(OFF_EN1) |=> (enable_control_1 == ($past(hwdata[REG_W-1:0]) & MASK_EN1)))
    else $error("enable word did not take written value");

  a_read_returns: assert property (
    s_read_take(OFF_FLAG3) |=> (hrdata == {16'h0000, $past(flag_status_3)}))
    else $error("read data differs from flag word");

  a_reset_zero: assert property (
    $rose(hresetn) |-> (flag_status_3 == REG_RESET) && (flag_status_4 == REG_RESET) &&
    (enable_control_0 == REG_RESET) && (request_out == 3'h0))
    else $error("register not zero after reset");

  a_request_gate: assert property (
    (flag2_events[B_SERIAL2_ERROR] && enable_control_2[B_SERIAL2_ERROR] && !wr_en2 && !wr_flag2)
      |=> request_out[B_SERIAL2_ERROR])
    else $error("enabled flag not forwarded");

  a_request_blocked: assert property (
    !enable_control_2[B_CAN1_RECEIVE] |-> !request_out[B_CAN1_RECEIVE])
    else $error("disabled source forwarded");

  a_status_read_clear: assert property (
    s_status_read_quiet |=> (irq_status_reg == 3'h0) && !irq)
    else $error("status not cleared by read");

  a_irq_follows_event: assert property (
    (flag4_events[B_DMA_CH6_DONE] && irq_mask_reg[B_IRQ_FLAG4] && !(wr_phase_reg && addr_reg == OFF_IRQ_MASK))
      |=> irq)
    else $error("unmasked event did not raise irq");

  a_bus_always_ready: assert property (
    hreadyout && (hresp == HRESP_OKAY))
    else $error("bus slave not ready or not okay");

  a_status_sticky: assert property (
    (irq_status_reg[B_IRQ_FLAG2] && !(rd_take && (rd_addr == OFF_IRQ_STAT))) |=> irq_status_reg[B_IRQ_FLAG2])
    else $error("status bit lost without a read");

  a_unmapped_read_zero: assert property (
    (rd_take && (rd_addr > OFF_IRQ_MASK)) |=> (hrdata == 32'h0000_0000))
    else $error("unmapped read not zero");

  a_upper_half_zero: assert property (
    rd_take |=> (hrdata[31:REG_W] == 16'h0000))
    else $error("upper read half not zero");

  a_flag2_write: assert property (
    s_write_phase(OFF_FLAG2) |=> (flag_status_2 == (($past(hwdata[REG_W-1:0]) | $past(flag2_events)) & MASK_FLAG2)))
    else $error("flag word did not take written value");

  a_flag4_hold: assert property (
    (!wr_flag4 && (flag4_events == 16'h0000)) |=> $stable(flag_status_4))
    else $error("flag word changed without event or write");

  a_enable_hold: assert property (
    !wr_en0 |=> $stable(enable_control_0))
    else $error("enable word changed without a write");

  a_request_forward: assert property (
    (flag_status_2[B_SERIAL2_EVENT] && enable_control_2[B_SERIAL2_EVENT]) |-> request_out[B_SERIAL2_EVENT])
    else $error("flagged and enabled source not forwarded");

  a_irq_masked_off: assert property (
    (irq_mask_reg == 3'h0) |-> !irq)
    else $error("irq raised with every status bit masked");

  a_mask_write: assert property (
    (wr_phase_reg && (addr_reg == OFF_IRQ_MASK)) |=> (irq_mask_reg == $past(hwdata[EVT_W-1:0])))
    else $error("mask did not take written value");

  a_flag_ignores_enable: assert property (
    (flag2_events[B_CAN1_RECEIVE] && !enable_control_2[B_CAN1_RECEIVE]) |=> flag_status_2[B_CAN1_RECEIVE])
    else $error("disabled source did not set its flag");

  a_write_phase_taken: assert property (
    (access_take && hwrite) |=> wr_phase_reg)
    else $error("write address phase not followed by data phase");

  a_read_data_hold: assert property (
    !rd_take |=> $stable(hrdata))
    else $error("read data changed without a read");

  a_enable2_write: assert property (
    s_write_phase(OFF_EN2) |=> (enable_control_2 == ($past(hwdata[REG_W-1:0]) & MASK_EN2)))
    else $error("third enable word did not take written value");

endmodule

// >>> include/irq_flag_pkg.sv
// shared constants for the interrupt flag and enable bank
package irq_flag_pkg;

  localparam int          REG_W        = 16;
  localparam int          EVT_W        = 3;
  localparam logic [15:0] REG_RESET    = 16'h0000;

  // register byte offsets
  localparam logic [7:0]  OFF_FLAG2    = 8'h00;
  localparam logic [7:0]  OFF_FLAG3    = 8'h04;
  localparam logic [7:0]  OFF_FLAG4    = 8'h08;
  localparam logic [7:0]  OFF_EN0      = 8'h0C;
  localparam logic [7:0]  OFF_EN1      = 8'h10;
  localparam logic [7:0]  OFF_EN2      = 8'h14;
  localparam logic [7:0]  OFF_IRQ_STAT = 8'h18;
  localparam logic [7:0]  OFF_IRQ_MASK = 8'h1C;
  localparam int          ADDR_LSB     = 2;
  localparam int          ADDR_MSB     = 7;

  // implemented bits of each register
  localparam logic [15:0] MASK_FLAG2   = 16'h0007;
  localparam logic [15:0] MASK_FLAG3   = 16'h39FF;
  localparam logic [15:0] MASK_FLAG4   = 16'h00F6;
  localparam logic [15:0] MASK_EN0     = 16'h7FFF;
  localparam logic [15:0] MASK_EN1     = 16'hFFFB;
  localparam logic [15:0] MASK_EN2     = 16'hDFFF;
  localparam logic [2:0]  MASK_IRQ     = 3'h7;

  // flag_status_2 fields
  localparam int B_CAN1_RECEIVE   = 2;
  localparam int B_SERIAL2_EVENT  = 1;
  localparam int B_SERIAL2_ERROR  = 0;
  // flag_status_3 fields
  localparam int B_DMA_CH5_DONE   = 13;
  localparam int B_CODEC_EVENT    = 12;
  localparam int B_CODEC_ERROR    = 11;
  localparam int B_CAN2_EVENT     = 8;
  localparam int B_CAN2_RECEIVE   = 7;
  localparam int B_EXT_IRQ4       = 6;
  localparam int B_EXT_IRQ3       = 5;
  localparam int B_TIMER9         = 4;
  localparam int B_TIMER8         = 3;
  localparam int B_I2C2_MASTER    = 2;
  localparam int B_I2C2_SLAVE     = 1;
  localparam int B_TIMER7         = 0;
  // flag_status_4 fields
  localparam int B_CAN2_TRANSMIT  = 7;
  localparam int B_CAN1_TRANSMIT  = 6;
  localparam int B_DMA_CH7_DONE   = 5;
  localparam int B_DMA_CH6_DONE   = 4;
  localparam int B_UART2_ERROR    = 2;
  localparam int B_UART1_ERROR    = 1;

  // interrupt status bits, one per flag register
  localparam int B_IRQ_FLAG2      = 0;
  localparam int B_IRQ_FLAG3      = 1;
  localparam int B_IRQ_FLAG4      = 2;

  // ahb encodings
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic        HRESP_OKAY    = 1'h0;

endpackage

// >>> tb/testbench.sv
// self-checking bench for the interrupt flag and enable bank
`timescale 1ns/1ps
module testbench
  import irq_flag_pkg::*;
();
  logic              hclk;
  logic              hresetn;
  logic              hsel;
  logic              hwrite;
  logic [31:0]       haddr;
  logic [31:0]       hwdata;
  logic [1:0]        htrans;
  logic [2:0]        hsize;
  logic [REG_W-1:0]  ev2;
  logic [REG_W-1:0]  ev3;
  logic [REG_W-1:0]  ev4;
  wire               hready;
  wire               hresp;
  wire  [31:0]       hrdata;
  wire  [REG_W-1:0]  fs3;
  wire  [REG_W-1:0]  fs4;
  wire  [REG_W-1:0]  en0;
  wire  [REG_W-1:0]  en1;
  wire  [EVT_W-1:0]  request_out;
  wire               irq;
  int                failures;
  int                checks;
  logic [31:0]       d;
  logic [7:0]        offs [6];
  logic [15:0]       masks [6];

  interrupt_flag_enable_bank dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
    .flag2_events(ev2), .flag3_events(ev3), .flag4_events(ev4), .flag_status_3(fs3), .flag_status_4(fs4),
    .enable_control_0(en0), .enable_control_1(en1), .request_out(request_out), .irq(irq)
  );

  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    if (failures == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // waits for a rising edge with hready high and takes hrdata at that same edge
  task automatic wait_ready(output logic [31:0] rdv);
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
      if (n > 100) begin
        failures++;
        final_report();
      end
    end while (hready !== 1'b1);
    rdv = hrdata;
  endtask

  // one single transfer; e3 and e4 pulse flag events in the data phase
  task automatic xfer(input logic is_wr, input logic [7:0] a, input logic [31:0] wd, input logic [15:0] e3,
                      input logic [15:0] e4, output logic [31:0] rdv);
    logic [31:0] dummy;
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= is_wr;
    wait_ready(dummy);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    ev3 <= e3;
    ev4 <= e4;
    wait_ready(rdv);
    ev3 <= 16'h0000;
    ev4 <= 16'h0000;
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] dummy;
    xfer(1'b1, a, wd, 16'h0000, 16'h0000, dummy);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    xfer(1'b0, a, 32'h00000000, 16'h0000, 16'h0000, v);
  endtask

  task automatic pulse(input logic [15:0] e2, input logic [15:0] e3, input logic [15:0] e4);
    @(posedge hclk);
    ev2 <= e2;
    ev3 <= e3;
    ev4 <= e4;
    @(posedge hclk);
    ev2 <= 16'h0000;
    ev3 <= 16'h0000;
    ev4 <= 16'h0000;
    #1;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    failures = 0;
    checks = 0;
    offs = '{OFF_FLAG2, OFF_FLAG3, OFF_FLAG4, OFF_EN0, OFF_EN1, OFF_EN2};
    masks = '{MASK_FLAG2, MASK_FLAG3, MASK_FLAG4, MASK_EN0, MASK_EN1, MASK_EN2};
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 32'h00000000;
    hwdata = 32'h00000000;
    htrans = 2'h0;
    hsize = 3'h2;
    ev2 = 16'h0000;
    ev3 = 16'h0000;
    ev4 = 16'h0000;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd(offs[i], d);
      check("reset value", d, 32'h00000000);
      wr(offs[i], 32'hFFFFFFFF);
      rd(offs[i], d);
      check("ones read back", d, {16'h0000, masks[i]});
    end
    check("hresp", 32'(hresp), 32'(HRESP_OKAY));
    check("flag3 out", 32'(fs3), 32'(MASK_FLAG3));
    check("en1 out", 32'(en1), 32'(MASK_EN1));
    for (int i = 0; i < 6; i++) begin
      wr(offs[i], 32'h00000000);
      rd(offs[i], d);
      check("zeros read back", d, 32'h00000000);
    end
    wr(8'h20, 32'hFFFFFFFF);
    rd(8'h20, d);
    check("unmapped", d, 32'h00000000);
    // every event line at once sets exactly the implemented flags, enables stay shut
    pulse(16'hFFFF, 16'hFFFF, 16'hFFFF);
    check("flag3 events", 32'(fs3), 32'(MASK_FLAG3));
    check("flag4 events", 32'(fs4), 32'(MASK_FLAG4));
    check("requests blocked", 32'(request_out), 32'h0);
    rd(OFF_FLAG2, d);
    check("flag2 events", d, 32'(MASK_FLAG2));
    check("en0 untouched", 32'(en0), 32'h0);
    rd(OFF_IRQ_STAT, d);
    check("irq status", d, 32'h00000007);
    rd(OFF_IRQ_STAT, d);
    check("irq status cleared", d, 32'h00000000);
    // one enable at a time passes only its own request
    for (int b = 0; b < 3; b++) begin
      wr(OFF_FLAG2, 32'h00000000);
      check("flag2 cleared", 32'(request_out), 32'h0);
      wr(OFF_EN2, 32'h00000001 << b);
      pulse(16'h0007, 16'h0000, 16'h0000);
      check("request per enable", 32'(request_out), 32'h1 << b);
    end
    wr(OFF_EN2, 32'h00000007);
    check("forced flags", 32'(request_out), 32'h7);
    // event wins against a clearing write in the same edge
    pulse(16'h0000, 16'h2000, 16'h0000);
    xfer(1'b1, OFF_FLAG3, 32'h00000000, 16'h0001, 16'h0000, d);
    check("event beats clear", 32'(fs3), 32'h00000001);
    xfer(1'b1, OFF_FLAG4, 32'h00000000, 16'h0000, 16'h0002, d);
    check("flag4 event beats clear", 32'(fs4), 32'h00000002);
    wr(OFF_FLAG3, 32'h00000000);
    check("flag3 cleared", 32'(fs3), 32'h0);
    // summary interrupt: raise, mask, clear
    wr(OFF_IRQ_MASK, 32'h00000007);
    rd(OFF_IRQ_MASK, d);
    check("irq mask", d, 32'h00000007);
    rd(OFF_IRQ_STAT, d);
    check("irq idle", 32'(irq), 32'h0);
    pulse(16'h0000, 16'h0000, 16'h0012);
    check("irq raised", 32'(irq), 32'h1);
    wr(OFF_IRQ_MASK, 32'h00000003);
    check("irq masked", 32'(irq), 32'h0);
    wr(OFF_IRQ_MASK, 32'h00000007);
    rd(OFF_IRQ_STAT, d);
    check("irq source", d, 32'h00000004);
    check("irq cleared", 32'(irq), 32'h0);
    // reset in mid-run
    wr(OFF_EN0, 32'hFFFFFFFF);
    check("en0 written", 32'(en0), 32'(MASK_EN0));
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    #1;
    check("reset flag4", 32'(fs4), 32'h0);
    check("reset en0", 32'(en0), 32'h0);
    @(posedge hclk);
    hresetn <= 1'b1;
    rd(OFF_EN2, d);
    check("reset en2", d, 32'h00000000);
    final_report();
  end
endmodule
